// File: core/band_ctrl_pkg.sv
// Constants, encodings and the register map of the encrypted band access controller.
// Assumes a 32-bit AXI4-Lite master and a one-word-per-cycle media stream.
package band_ctrl_pkg;
   localparam int NBANDS = 16;
   localparam int ADDR_W = 8;
   // Register byte offsets
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_CRED = 8'h04;
   localparam logic [7:0] A_ARG0 = 8'h08;
   localparam logic [7:0] A_ARG1 = 8'h0C;
   localparam logic [7:0] A_STATUS = 8'h10;
   localparam logic [7:0] A_FACTORY = 8'h14;
   localparam logic [7:0] A_RNG = 8'h18;
   localparam logic [7:0] A_BANDSTAT = 8'h1C;
   // Command word fields
   localparam int CMD_BAND_LSB = 0;
   localparam int CMD_OP_LSB = 4;
   localparam int CMD_CDB_LSB = 8;
   // Security protocol operation codes carried in the command word
   localparam logic [7:0] SEC_OUT_OPCODE = 8'hB5;
   localparam logic [7:0] SEC_IN_OPCODE = 8'hA2;
   // Lock configuration bits in ARG0
   localparam int CFG_RELOCK_BIT = 0;
   localparam int CFG_RD_BIT = 1;
   localparam int CFG_WR_BIT = 2;
   // Status register bits
   localparam int ST_RES_LSB = 0;
   localparam int ST_FW_BIT = 2;
   localparam int ST_READY_BIT = 3;
   localparam int ST_MERR_BIT = 4;
   localparam int BS_ALLOC_LSB = 16;
   // Command results
   localparam logic [1:0] RES_NONE = 2'h0;
   localparam logic [1:0] RES_OK = 2'h1;
   localparam logic [1:0] RES_DENIED = 2'h2;
   localparam logic [1:0] RES_BAD = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [3:0] GLOBAL_BAND = 4'h0;
   localparam logic [3:0] FIRST_GATED_BAND = 4'h2;
   // Default credential, arbitrary value
   localparam logic [31:0] FACTORY_CRED = 32'h5A3C_96E1;
   localparam logic [31:0] LFSR_SEED = 32'hACE1_2468;
   localparam logic [31:0] LFSR_TAPS = 32'h8020_0003;
   localparam int CIPHER_ROT = 5;

   typedef enum logic [3:0] {
      OP_UNLOCK, OP_LOCK, OP_SET_RANGE, OP_ENABLE, OP_ERASE, OP_SET_BAND_CRED,
      OP_SET_ERASE_CRED, OP_SET_OWNER_CRED, OP_FW_ENABLE, OP_FW_DISABLE, OP_SET_LOCKCFG
   } op_t;

   typedef enum logic [1:0] {ST_WRAP, ST_KEYS, ST_IDLE} state_t;
endpackage : band_ctrl_pkg

// File: core/band_access_ctrl.sv
// Band access controller: AXI4-Lite command registers, band table, credentials,
// per-band wrapped keys, random source and the inline media cipher.
// Assumes media words arrive synchronous to aclk, one per cycle at most.
//
// Function
// - Inline cipher per port enciphers writes and deciphers reads with the band key.
// - Cipher applies to every media word not refused; refused words give zero, nothing bypasses it.
// - Keys come from the internal random source and are never readable.
// - Keys are stored wrapped, unwrapped only inside the cipher path.
// - Each of sixteen bands has its own key, chosen by addressed band.
// - Commands without a credential valid for that operation are refused.
// - Owner authority sets firmware download, reached by owner or factory credential.
// - Lock authority needs erase credential or the band's own credential.
// - All credentials start as the factory credential, which host may read.
// - Random source feeds key generation and a host-readable random register.
// - Power loss locks a band only if relock, read-lock and write-lock set.
// - Locked bands refuse every media read and write until unlocked.
// - Firmware download starts unlocked from reset.
// - At reset only the global band exists, covering all addresses.
// - Band 1 gets a start and length; those blocks leave the global band.
// - Bands 2 to 15 need enabling under erase credential before ranges.
// - Overlapping ranges are refused; adjacent ranges are allowed.
// - Each band's key and credential can be replaced on request.
// - Erase overwrites the band key with a fresh one, keeping no history.
// - Security protocol out is B5h, security protocol in is A2h.
`timescale 1ns/1ps
module band_access_ctrl
   import band_ctrl_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic power_loss_event,
   input wire logic media_valid,
   input wire logic media_write,
   input wire logic [31:0] media_lba,
   input wire logic [31:0] media_data,
   output logic media_ready,
   output logic media_done,
   output logic media_err,
   output logic [31:0] media_out,
   output logic [3:0] media_band,
   output logic fw_download_allow
);

   typedef struct packed {
      state_t st;
      logic [3:0] init_idx;
      logic aw_have;
      logic w_have;
      logic [ADDR_W-1:0] waddr;
      logic [31:0] wdat;
      logic [3:0] wstb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [31:0] cred;
      logic [31:0] arg0;
      logic [31:0] arg1;
      logic [1:0] result;
      logic fw_unlocked;
      logic [31:0] rng;
      logic [31:0] wrap;
      logic [NBANDS-1:0][31:0] wkey;
      logic [NBANDS-1:0][31:0] bcred;
      logic [NBANDS-1:0][31:0] bstart;
      logic [NBANDS-1:0][31:0] blast;
      logic [NBANDS-1:0] en;
      logic [NBANDS-1:0] alloc;
      logic [NBANDS-1:0] locked;
      logic [NBANDS-1:0] relock;
      logic [NBANDS-1:0] rd_lock;
      logic [NBANDS-1:0] wr_lock;
      logic [31:0] erase_cred;
      logic [31:0] owner_cred;
      logic mdone;
      logic merr;
      logic [31:0] mout;
      logic [3:0] mband;
   } regs_t;

   regs_t r_q;
   regs_t r_d;

   function automatic logic [31:0] swap_half(input logic [31:0] k);
      return {k[15:0], k[31:16]};
   endfunction : swap_half

   function automatic logic [31:0] encipher(input logic [31:0] x, input logic [31:0] k,
                                            input logic [31:0] iv);
      logic [31:0] t;
      t = x ^ iv ^ k;
      return {t[31-CIPHER_ROT:0], t[31:32-CIPHER_ROT]} ^ swap_half(k);
   endfunction : encipher

   function automatic logic [31:0] decipher(input logic [31:0] y, input logic [31:0] k,
                                            input logic [31:0] iv);
      logic [31:0] t;
      t = y ^ swap_half(k);
      return {t[CIPHER_ROT-1:0], t[31:CIPHER_ROT]} ^ k ^ iv;
   endfunction : decipher

   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {1'b0, x[31:1]} ^ (x[0] ? LFSR_TAPS : 32'h0000_0000);
   endfunction : lfsr_next

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] stb);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (stb[i]) begin
            m[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return m;
   endfunction : merge

   ////////////////////////////////////////////////////////////////////////////////
   // Handshakes and command decode

   logic idle;
   logic wr_go;
   logic cmd_fire;
   logic [3:0] cb;
   op_t cop;
   logic [7:0] cdb;
   logic auth_band;
   logic auth_erase;
   logic auth_owner;
   logic cmd_auth;
   logic [32:0] cmd_end;
   logic [NBANDS-1:0] hit;
   logic [NBANDS-1:0] ovl;
   logic [NBANDS-1:0] relock_mask;
   logic [3:0] sel;
   logic refuse;
   logic [31:0] band_key;

   assign idle = (r_q.st == ST_IDLE);
   assign awready = ce & idle & ~r_q.aw_have & ~r_q.bvalid;
   assign wready = ce & idle & ~r_q.w_have & ~r_q.bvalid;
   assign arready = ce & ~r_q.rvalid;
   assign media_ready = ce;
   assign wr_go = r_q.aw_have & r_q.w_have;
   assign cmd_fire = wr_go && (r_q.waddr == A_CMD);
   assign cb = r_q.wdat[CMD_BAND_LSB +: 4];
   assign cop = op_t'(r_q.wdat[CMD_OP_LSB +: 4]);
   assign cdb = r_q.wdat[CMD_CDB_LSB +: 8];
   assign auth_band = (r_q.cred == r_q.bcred[cb]) || (r_q.cred == r_q.erase_cred);
   assign auth_erase = (r_q.cred == r_q.erase_cred);
   assign auth_owner = (r_q.cred == r_q.owner_cred) || (r_q.cred == FACTORY_CRED);
   assign cmd_end = {1'b0, r_q.arg0} + {1'b0, r_q.arg1} - 33'h0_0000_0001;
   assign relock_mask = r_q.relock & r_q.rd_lock & r_q.wr_lock;

   always_comb begin
      case (cop)
         OP_ENABLE, OP_SET_ERASE_CRED: cmd_auth = auth_erase;
         OP_SET_OWNER_CRED, OP_FW_ENABLE, OP_FW_DISABLE: cmd_auth = auth_owner;
         default: cmd_auth = auth_band;
      endcase
   end

   genvar g;
   for (g = 0; g < NBANDS; g++) begin : g_band
      assign hit[g] = (g != 0) && r_q.alloc[g] && (media_lba >= r_q.bstart[g])
                      && (media_lba <= r_q.blast[g]);
      // Inclusive overlap test, adjacent ranges pass
      assign ovl[g] = r_q.alloc[g] && (4'(g) != cb)
                      && !((cmd_end[31:0] < r_q.bstart[g]) || (r_q.arg0 > r_q.blast[g]));
   end

   // Ranges never overlap, so at most one hit is set
   always_comb begin
      sel = GLOBAL_BAND;
      for (int i = 1; i < NBANDS; i++) begin
         if (hit[i]) begin
            sel = 4'(i);
         end
      end
   end

   // Unwrapped key exists only on this path into the cipher
   assign band_key = r_q.wkey[sel] ^ r_q.wrap;
   // Locked band or keys not ready
   assign refuse = r_q.locked[sel] | ~idle;

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      r_d = r_q;
      if (!aresetn) begin
         r_d = '0;
         r_d.st = ST_WRAP;
         r_d.rng = LFSR_SEED;
         // Firmware download unlocked from the factory
         r_d.fw_unlocked = 1'b1;
         // Every credential starts as the factory one
         for (int i = 0; i < NBANDS; i++) begin
            r_d.bcred[i] = FACTORY_CRED;
         end
         r_d.erase_cred = FACTORY_CRED;
         r_d.owner_cred = FACTORY_CRED;
         // No extra band allocated, global band covers all
         r_d.alloc = '0;
      end else begin
         r_d.rng = lfsr_next(r_q.rng);
         case (r_q.st)
            ST_WRAP: begin
               r_d.wrap = r_q.rng;
               r_d.st = ST_KEYS;
            end
            ST_KEYS: begin
               // Keys drawn from the random source, one band per cycle
               r_d.wkey[r_q.init_idx] = r_q.rng ^ r_q.wrap;
               r_d.init_idx = r_q.init_idx + 4'h1;
               if (r_q.init_idx == 4'(NBANDS - 1)) begin
                  r_d.st = ST_IDLE;
               end
            end
            default: r_d.st = ST_IDLE;
         endcase

         // Write address and data may arrive in either order
         if (awvalid && awready) begin
            r_d.aw_have = 1'b1;
            r_d.waddr = awaddr[ADDR_W-1:0];
         end
         if (wvalid && wready) begin
            r_d.w_have = 1'b1;
            r_d.wdat = wdata;
            r_d.wstb = wstrb;
         end
         if (r_q.bvalid && bready) begin
            r_d.bvalid = 1'b0;
         end
         if (wr_go) begin
            r_d.aw_have = 1'b0;
            r_d.w_have = 1'b0;
            r_d.bvalid = 1'b1;
            r_d.bresp = RESP_OKAY;
            if (r_q.waddr == A_CMD) begin
               r_d.result = RES_OK;
            end else if (r_q.waddr == A_CRED) begin
               r_d.cred = merge(r_q.cred, r_q.wdat, r_q.wstb);
            end else if (r_q.waddr == A_ARG0) begin
               r_d.arg0 = merge(r_q.arg0, r_q.wdat, r_q.wstb);
            end else if (r_q.waddr == A_ARG1) begin
               r_d.arg1 = merge(r_q.arg1, r_q.wdat, r_q.wstb);
            end else if ((r_q.waddr == A_STATUS) || (r_q.waddr == A_FACTORY)
                         || (r_q.waddr == A_RNG) || (r_q.waddr == A_BANDSTAT)) begin
               r_d.bresp = RESP_OKAY;
            end else begin
               r_d.bresp = RESP_SLVERR;
            end
         end

         if (cmd_fire) begin
            // Only a security protocol out payload carries a command
            if (cdb != SEC_OUT_OPCODE) begin
               r_d.result = RES_BAD;
            end else if (!cmd_auth) begin
               r_d.result = RES_DENIED;
            end else begin
               case (cop)
                  OP_UNLOCK: r_d.locked[cb] = 1'b0;
                  OP_LOCK: r_d.locked[cb] = 1'b1;
                  OP_SET_RANGE: begin
                     if (r_q.arg1 == 32'h0000_0000) begin
                        // Global band is never in the table, so freeing it changes nothing
                        r_d.alloc[cb] = 1'b0;
                        r_d.result = (cb == GLOBAL_BAND) ? RES_BAD : RES_OK;
                     end else if (cb == GLOBAL_BAND) begin
                        r_d.result = RES_BAD;
                     // Bands from 2 up must be enabled first
                     end else if ((cb >= FIRST_GATED_BAND) && !r_q.en[cb]) begin
                        r_d.result = RES_BAD;
                     // Refuse overlap or a range past the top address
                     end else if ((|ovl) || cmd_end[32]) begin
                        r_d.result = RES_BAD;
                     end else begin
                        // Allocated blocks leave the global band
                        r_d.alloc[cb] = 1'b1;
                        r_d.bstart[cb] = r_q.arg0;
                        r_d.blast[cb] = cmd_end[31:0];
                     end
                  end
                  OP_ENABLE: r_d.en[cb] = 1'b1;
                  // Fresh key overwrites the old one, no copy kept
                  OP_ERASE: r_d.wkey[cb] = r_q.rng ^ r_q.wrap;
                  OP_SET_BAND_CRED: r_d.bcred[cb] = r_q.arg1;
                  OP_SET_ERASE_CRED: r_d.erase_cred = r_q.arg1;
                  OP_SET_OWNER_CRED: r_d.owner_cred = r_q.arg1;
                  OP_FW_ENABLE: r_d.fw_unlocked = 1'b1;
                  OP_FW_DISABLE: r_d.fw_unlocked = 1'b0;
                  OP_SET_LOCKCFG: begin
                     r_d.relock[cb] = r_q.arg0[CFG_RELOCK_BIT];
                     r_d.rd_lock[cb] = r_q.arg0[CFG_RD_BIT];
                     r_d.wr_lock[cb] = r_q.arg0[CFG_WR_BIT];
                  end
                  default: r_d.result = RES_BAD;
               endcase
            end
         end

         // Power loss wins over an unlock in the same cycle
         if (power_loss_event) begin
            r_d.locked = r_d.locked | relock_mask;
         end

         // Read channel; key registers have no read path at all
         if (r_q.rvalid && rready) begin
            r_d.rvalid = 1'b0;
         end
         if (arvalid && arready) begin
            r_d.rvalid = 1'b1;
            r_d.rresp = RESP_OKAY;
            r_d.rdata = 32'h0000_0000;
            if (araddr[ADDR_W-1:0] == A_CRED) begin
               r_d.rdata = r_q.cred;
            end else if (araddr[ADDR_W-1:0] == A_ARG0) begin
               r_d.rdata = r_q.arg0;
            end else if (araddr[ADDR_W-1:0] == A_ARG1) begin
               r_d.rdata = r_q.arg1;
            end else if (araddr[ADDR_W-1:0] == A_STATUS) begin
               r_d.rdata[ST_RES_LSB +: 2] = r_q.result;
               r_d.rdata[ST_FW_BIT] = r_q.fw_unlocked;
               r_d.rdata[ST_READY_BIT] = idle;
               r_d.rdata[ST_MERR_BIT] = r_q.merr;
            end else if (araddr[ADDR_W-1:0] == A_FACTORY) begin
               // Factory credential readable over the interface
               r_d.rdata = FACTORY_CRED;
            end else if (araddr[ADDR_W-1:0] == A_RNG) begin
               r_d.rdata = r_q.rng;
            end else if (araddr[ADDR_W-1:0] == A_BANDSTAT) begin
               r_d.rdata[NBANDS-1:0] = r_q.locked;
               r_d.rdata[BS_ALLOC_LSB +: NBANDS] = r_q.alloc;
            end else if (araddr[ADDR_W-1:0] != A_CMD) begin
               r_d.rresp = RESP_SLVERR;
            end
         end

         // Media path, one word per cycle
         r_d.mdone = media_valid;
         if (media_valid) begin
            r_d.mband = sel;
            // Refused word: error and zero data
            r_d.merr = refuse;
            if (refuse) begin
               r_d.mout = 32'h0000_0000;
            // Cipher with the addressed band's key, no bypass
            end else if (media_write) begin
               r_d.mout = encipher(media_data, band_key, media_lba);
            end else begin
               r_d.mout = decipher(media_data, band_key, media_lba);
            end
         end
      end
   end

   // Reset acts even while the clock enable is low
   always_ff @(posedge aclk) begin
      if (!aresetn || ce) begin
         r_q <= r_d;
      end
   end

   assign bvalid = r_q.bvalid;
   assign bresp = r_q.bresp;
   assign rvalid = r_q.rvalid;
   assign rresp = r_q.rresp;
   assign rdata = r_q.rdata;
   assign media_done = r_q.mdone & ce;
   assign media_err = r_q.merr;
   assign media_out = r_q.mout;
   assign media_band = r_q.mband;
   assign fw_download_allow = r_q.fw_unlocked;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb_clk @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_locked_access;
      ce && media_valid && refuse;
   endsequence
   sequence s_refused_answer;
      media_err && (media_out == 32'h0000_0000) && (r_q.mdone == 1'b1);
   endsequence
   sequence s_range_cmd;
      ce && cmd_fire && (cdb == SEC_OUT_OPCODE) && cmd_auth && (cop == OP_SET_RANGE)
      && (r_q.arg1 != 32'h0000_0000);
   endsequence

   lock_refuse_a: assert property (s_locked_access |=> s_refused_answer)
      else $error("locked band access not refused");
   refuse_nodata_a: assert property (r_q.mdone && r_q.merr |-> media_out == 32'h0000_0000)
      else $error("refused access carried data");
   cipher_round_a: assert property (media_valid |->
      decipher(encipher(media_data, band_key, media_lba), band_key, media_lba) == media_data)
      else $error("cipher does not invert");
   global_band_a: assert property (ce && media_valid && !(|hit) |=> media_band == GLOBAL_BAND)
      else $error("unmatched access not on global band");
   relock_power_a: assert property (ce && power_loss_event |=>
      ((r_q.locked & $past(relock_mask)) == $past(relock_mask)))
      else $error("power loss did not lock configured band");
   denied_cmd_a: assert property (ce && cmd_fire && (cdb == SEC_OUT_OPCODE) && !cmd_auth
      |=> r_q.result == RES_DENIED && $stable(r_q.locked))
      else $error("unauthorised command not denied");
   gated_band_a: assert property (s_range_cmd ##0 (cb >= FIRST_GATED_BAND) && !r_q.en[cb]
      |=> r_q.result == RES_BAD && $stable(r_q.alloc))
      else $error("disabled band got a range");
   overlap_a: assert property (s_range_cmd ##0 (|ovl) |=> r_q.result == RES_BAD)
      else $error("overlapping range accepted");
   erase_key_a: assert property (ce && cmd_fire && (cdb == SEC_OUT_OPCODE) && cmd_auth
      && (cop == OP_ERASE) |=> r_q.wkey[$past(cb)] == ($past(r_q.rng) ^ r_q.wrap))
      else $error("erase did not load a fresh key");
   factory_state_a: assert property ($past(!aresetn) |-> fw_download_allow
      && (r_q.alloc == '0) && (r_q.erase_cred == FACTORY_CRED))
      else $error("factory defaults wrong after reset");
endmodule : band_access_ctrl

// File: testbench/media_host.sv
// Media host model: offers one block word per transfer and collects the reply.
// Assumes the controller shares aclk and takes a word whenever ce is high.
`timescale 1ns/1ps
module media_host (
   input wire logic aclk,
   input wire logic media_done,
   input wire logic media_err,
   input wire logic [31:0] media_out,
   input wire logic [3:0] media_band,
   output logic media_valid,
   output logic media_write,
   output logic [31:0] media_lba,
   output logic [31:0] media_data
);
   initial media_valid = 1'b0;
   initial media_write = 1'b0;
   initial media_lba = 32'h0;
   initial media_data = 32'h0;
   //////////////////////////////////////////////////////////////////
   // Host issues words
   task automatic xfer(input logic wr, input logic [31:0] lba, input logic [31:0] d,
      output logic e, output logic [31:0] o, output logic [3:0] b);
      @(posedge aclk);
      media_valid <= 1'b1;
      media_write <= wr;
      media_lba <= lba;
      media_data <= d;
      @(posedge aclk);
      media_valid <= 1'b0;
      // Released lines show the inverse so a stale word never looks valid
      media_lba <= ~lba;
      media_data <= ~d;
      e = 1'bx;
      for (int k = 0; k < 4; k++) begin
         @(posedge aclk);
         if (media_done) begin
            e = media_err;
            o = media_out;
            b = media_band;
            break;
         end
      end
   endtask : xfer
endmodule : media_host

// File: testbench/testbench.sv
// Bench for the band access controller: AXI4-Lite command tasks and media words.
// Assumes a 100 MHz aclk and the register map of the controller package.
`timescale 1ns/1ps
module testbench;
   import band_ctrl_pkg::*;
   localparam logic [31:0] D = 32'hC0DE_1234;
   localparam logic [31:0] FC = FACTORY_CRED;
   logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, power_loss_event = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, media_valid, media_write;
   logic media_ready, media_done, media_err, fw_download_allow, me;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, media_lba, media_data, media_out, mo, c, c2, p;
   logic [31:0] v = 32'h0;
   logic [3:0] media_band, mb;
   int n_errors = 0, n_tests = 0;
   initial forever #5 aclk = ~aclk;
   band_access_ctrl dut (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .power_loss_event, .media_valid, .media_write, .media_lba, .media_data,
      .media_ready, .media_done, .media_err, .media_out, .media_band, .fw_download_allow);
   media_host host (.aclk, .media_done, .media_err, .media_out, .media_band, .media_valid,
      .media_write, .media_lba, .media_data);
   //////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("Checks %0d, errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic hang;
      n_errors++;
      $display("[FAIL] %0t bus wait ran out", $time);
      close_out();
   endtask : hang
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
      logic aw, w, b;
      @(posedge aclk);
      aw = 1'b1;
      w = 1'b1;
      b = 1'b1;
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int k = 0; k < 100 && b; k++) begin
         @(posedge aclk);
         if (aw && awready) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
         if (bvalid) begin
            b = 1'b0;
            rs = bresp;
            bready <= 1'b0;
         end
      end
      if (b) hang();
   endtask : axw
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      logic ar, rd;
      @(posedge aclk);
      ar = 1'b1;
      rd = 1'b1;
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int k = 0; k < 100 && rd; k++) begin
         @(posedge aclk);
         if (ar && arready) begin
            ar = 1'b0;
            arvalid <= 1'b0;
         end else if (rvalid) begin
            rd = 1'b0;
            d = rdata;
            rs = rresp;
            rready <= 1'b0;
         end
      end
      if (rd) hang();
   endtask : axr
   task automatic cmd(input logic [31:0] cr, a0, a1, input op_t op, input logic [3:0] bd);
      logic [1:0] rs;
      axw(A_CRED, cr, rs);
      axw(A_ARG0, a0, rs);
      axw(A_ARG1, a1, rs);
      axw(A_CMD, {16'h0, SEC_OUT_OPCODE, op, bd}, rs);
      axr(A_STATUS, v, rs);
      r = v[1:0];
   endtask : cmd
   task automatic mx(input logic wr, input logic [31:0] lba, input logic [31:0] d);
      host.xfer(wr, lba, d, me, mo, mb);
      if (me === 1'bx) hang();
   endtask : mx
   //////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      for (int k = 0; k < 40 && !v[ST_READY_BIT]; k++) axr(A_STATUS, v, r);
      if (!v[ST_READY_BIT]) hang();
      chk(v[ST_FW_BIT], 1'b1);
      axr(A_FACTORY, v, r);
      chk(v, FC);
      axr(A_RNG, v, r);
      axr(A_RNG, p, r);
      chk(v !== p, 1'b1);
      axr(8'h40, v, r);
      chk(r, RESP_SLVERR);
      axw(8'h44, D, r);
      chk(r, RESP_SLVERR);
      cmd(32'h0, 32'h0, 32'h0, OP_FW_DISABLE, 4'h0);
      chk(r, RES_DENIED);
      axw(A_CMD, {16'h0, SEC_IN_OPCODE, OP_FW_DISABLE, 4'h0}, r);
      axr(A_STATUS, v, r);
      chk(v[1:0], RES_BAD);
      chk(fw_download_allow, 1'b1);
      cmd(FC, 32'h0, 32'h0, OP_FW_DISABLE, 4'h0);
      chk(fw_download_allow, 1'b0);
      cmd(FC, 32'h0, 32'h0, OP_FW_ENABLE, 4'h0);
      chk(fw_download_allow, 1'b1);
      mx(1'b1, 32'h1800, D);
      chk(mb, GLOBAL_BAND);
      cmd(FC, 32'h1000, 32'h1000, OP_SET_RANGE, 4'h1);
      chk(r, RES_OK);
      mx(1'b1, 32'h1800, D);
      chk(mb, 4'h1);
      mx(1'b1, 32'h0FFF, D);
      chk(mb, GLOBAL_BAND);
      cmd(FC, 32'h2000, 32'h1000, OP_SET_RANGE, 4'h2);
      chk(r, RES_BAD);
      cmd(FC, 32'h0, 32'h0, OP_ENABLE, 4'h2);
      cmd(FC, 32'h1800, 32'h1000, OP_SET_RANGE, 4'h2);
      chk(r, RES_BAD);
      cmd(FC, 32'h2000, 32'h1000, OP_SET_RANGE, 4'h2);
      chk(r, RES_OK);
      mx(1'b1, 32'h2000, D);
      c2 = mo;
      chk(mb, 4'h2);
      chk(mo !== D, 1'b1);
      mx(1'b1, 32'h1800, D);
      c = mo;
      mx(1'b0, 32'h1800, c);
      chk(mo, D);
      cmd(FC, 32'h0, 32'h0, OP_ERASE, 4'h1);
      mx(1'b0, 32'h1800, c);
      chk(mo !== D, 1'b1);
      mx(1'b0, 32'h2000, c2);
      chk(mo, D);
      cmd(FC, 32'h0, 32'h0, OP_LOCK, 4'h1);
      mx(1'b0, 32'h1800, c);
      chk(me, 1'b1);
      chk(mo, 32'h0);
      cmd(FC, 32'h0, 32'h0, OP_UNLOCK, 4'h1);
      mx(1'b1, 32'h1800, D);
      chk(me, 1'b0);
      cmd(FC, 32'h7, 32'h0, OP_SET_LOCKCFG, 4'h2);
      cmd(FC, 32'h3, 32'h0, OP_SET_LOCKCFG, 4'h1);
      @(posedge aclk);
      power_loss_event <= 1'b1;
      @(posedge aclk);
      power_loss_event <= 1'b0;
      axr(A_BANDSTAT, v, r);
      chk(v[2:1], 2'b10);
      // Frozen block offers no handshake at all
      ce <= 1'b0;
      @(posedge aclk);
      chk({media_ready, arready, awready}, 3'b000);
      ce <= 1'b1;
      cmd(FC, 32'h0, 32'h1111, OP_SET_BAND_CRED, 4'h2);
      cmd(FC, 32'h0, 32'h2222, OP_SET_ERASE_CRED, 4'h0);
      cmd(32'h1111, 32'h0, 32'h0, OP_UNLOCK, 4'h2);
      chk(r, RES_OK);
      mx(1'b0, 32'h2000, c2);
      chk(me, 1'b0);
      close_out();
   end
endmodule : testbench
